// [ptab_pkg.sv]
// Shared constants for the point-table command handler and its master end.
// Overview of operation
// - C0 writes entry position, entries 01 to FF
// - C6 writes entry speed, entries 01 to FF
// - C7 writes entry acceleration time constant
// - C8 writes entry deceleration time constant
// - CA writes entry dwell value
// - CB writes entry auxiliary function
// - Mode 0 writes both copies, 1 RAM only
// - Master keeps frequent changes out of non-volatile copy
// - Station accepts data sent to its group
// - 9F with number 00 writes group setting
// - Response enable 0 suppresses read replies
// - 1F with number 00 reads group setting
// - 02/90 returns motor pulse absolute position
// - Pulse position overflows at 8192 revolutions
// - 02/91 returns command unit absolute position
// - 02/70 returns software version
// - Auxiliary read returns stored entry value
// - Master reads auxiliary with 64, entries 01-FF
`default_nettype none
package ptab_pkg;
   // ----------------------------------------------------------------
   // Command codes and data numbers
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_POS_WR = 8'hc0;
   localparam logic [7:0] CMD_SPD_WR = 8'hc6;
   localparam logic [7:0] CMD_ACC_WR = 8'hc7;
   localparam logic [7:0] CMD_DEC_WR = 8'hc8;
   localparam logic [7:0] CMD_DWL_WR = 8'hca;
   localparam logic [7:0] CMD_AUX_WR = 8'hcb;
   localparam logic [7:0] CMD_POS_RD = 8'h40;
   localparam logic [7:0] CMD_SPD_RD = 8'h50;
   localparam logic [7:0] CMD_ACC_RD = 8'h54;
   localparam logic [7:0] CMD_DEC_RD = 8'h58;
   localparam logic [7:0] CMD_DWL_RD = 8'h60;
   localparam logic [7:0] CMD_AUX_RD = 8'h64;
   localparam logic [7:0] CMD_GRP_WR = 8'h9f;
   localparam logic [7:0] CMD_GRP_RD = 8'h1f;
   localparam logic [7:0] CMD_MON_RD = 8'h02;
   localparam logic [7:0] DNO_GROUP = 8'h00;
   localparam logic [7:0] DNO_ABS_PULSE = 8'h90;
   localparam logic [7:0] DNO_ABS_CMD = 8'h91;
   localparam logic [7:0] DNO_VERSION = 8'h70;
   localparam logic [7:0] DNO_LAST = 8'hff;

   // ----------------------------------------------------------------
   // Table fields, write modes, group setting layout
   // ----------------------------------------------------------------
   localparam int FIELDS = 6;
   localparam logic [2:0] FLD_POS = 3'h0;
   localparam logic [2:0] FLD_SPD = 3'h1;
   localparam logic [2:0] FLD_ACC = 3'h2;
   localparam logic [2:0] FLD_DEC = 3'h3;
   localparam logic [2:0] FLD_DWL = 3'h4;
   localparam logic [2:0] FLD_AUX = 3'h5;
   localparam logic MODE_NV_RAM = 1'b0;
   localparam logic MODE_RAM = 1'b1;
   localparam int GRP_RSP_EN_BIT = 8;
   localparam logic [7:0] GRP_RESET = 8'h00;
   localparam logic GRP_RSP_EN_RESET = 1'b1;

   // ----------------------------------------------------------------
   // Position and timing
   // ----------------------------------------------------------------
   localparam int ENC_BITS = 18;
   localparam logic signed [15:0] OVF_REVS = 16'sh2000;
   localparam longint CLK_HZ = 100_000_000;
   localparam longint NV_GAP_S = 3600;
   localparam longint NV_GAP_CYCLES = NV_GAP_S * CLK_HZ;
   localparam logic [7:0] RSP_TIMEOUT_CYCLES = 8'h10;
   localparam logic [7:0] RELOAD_FIRST = 8'h00;
endpackage
`default_nettype wire

// [ptab_if.sv]
// Command and reply link between the master end and the station end.
`default_nettype none
interface ptab_if;
   logic cmd_valid;
   logic cmd_ready;
   logic [7:0] cmd_code;
   logic [7:0] cmd_dno;
   logic [31:0] cmd_data;
   logic cmd_mode;
   logic [7:0] cmd_dest;
   logic cmd_to_group;
   logic rsp_valid;
   logic [31:0] rsp_data;
   logic rsp_err;

   modport device (
      input cmd_valid, cmd_code, cmd_dno, cmd_data, cmd_mode, cmd_dest, cmd_to_group,
      output cmd_ready, rsp_valid, rsp_data, rsp_err
   );
   modport host (
      output cmd_valid, cmd_code, cmd_dno, cmd_data, cmd_mode, cmd_dest, cmd_to_group,
      input cmd_ready, rsp_valid, rsp_data, rsp_err
   );
endinterface
`default_nettype wire

// [ptab_device.sv]
// Station end: point table, group setting and monitor reads.
`default_nettype none
module ptab_device #(
   // Arbitrary neutral version code, ASCII "0001".
   parameter logic [31:0] SW_VERSION = 32'h30303031
) (
   input wire logic clk,
   input wire logic rst_n,
   ptab_if.device link,
   input wire logic [7:0] station_id,
   input wire logic signed [15:0] motor_rev,
   input wire logic [17:0] motor_pulse,
   input wire logic [31:0] cmd_unit_pos,
   output logic pos_overflow,
   output logic reload_busy,
   output logic [7:0] group_id,
   output logic rsp_enable
);
   typedef enum logic [0:0] {
      S_RELOAD = 1'b0,
      S_IDLE = 1'b1
   } dev_state_t;

   // -----------------------------------------------------------------
   // Storage
   // -----------------------------------------------------------------
   // The non-volatile copy has no reset: it models storage that
   // survives power loss, while the working copy is rebuilt from it.
   logic [31:0] ram_q [0:ptab_pkg::FIELDS-1][0:255];
   logic [31:0] nv_q [0:ptab_pkg::FIELDS-1][0:255];

   dev_state_t state_q, state_d;
   logic [7:0] idx_q, idx_d;
   logic [7:0] grp_q, grp_d;
   logic rsp_en_q, rsp_en_d;
   logic ovf_q, ovf_d;
   logic rsp_valid_q, rsp_valid_d;
   logic [31:0] rsp_data_q, rsp_data_d;
   logic rsp_err_q, rsp_err_d;
   logic ram_we, nv_we;
   logic [2:0] wr_fld;
   logic addressed;
   logic take;
   logic [31:0] abs_pulse;

   assign link.cmd_ready = (state_q == S_IDLE);
   assign take = link.cmd_valid && (state_q == S_IDLE);
   // Only the low 32 bits are replied, so the count wraps at the overflow limit.
   assign abs_pulse = 32'({motor_rev, motor_pulse});
   assign link.rsp_valid = rsp_valid_q;
   assign link.rsp_data = rsp_data_q;
   assign link.rsp_err = rsp_err_q;
   assign pos_overflow = ovf_q;
   assign reload_busy = (state_q == S_RELOAD);
   assign group_id = grp_q;
   assign rsp_enable = rsp_en_q;

   // -----------------------------------------------------------------
   // Command decode
   // -----------------------------------------------------------------
   always_comb begin
      // Group zero means no group, so a broadcast to zero is never taken.
      addressed = link.cmd_to_group
         ? (grp_q != ptab_pkg::GRP_RESET && link.cmd_dest == grp_q)
         : (link.cmd_dest == station_id);
      state_d = state_q;
      idx_d = idx_q;
      grp_d = grp_q;
      rsp_en_d = rsp_en_q;
      rsp_valid_d = 1'b0;
      rsp_data_d = rsp_data_q;
      rsp_err_d = 1'b0;
      ram_we = 1'b0;
      nv_we = 1'b0;
      wr_fld = ptab_pkg::FLD_POS;
      ovf_d = (motor_rev >= ptab_pkg::OVF_REVS) || (motor_rev <= -ptab_pkg::OVF_REVS);
      if (state_q == S_RELOAD) begin
         idx_d = idx_q + 8'h01;
         if (idx_q == ptab_pkg::DNO_LAST) begin
            state_d = S_IDLE;
         end
      end else if (take && addressed) begin
         unique case (link.cmd_code)
            ptab_pkg::CMD_POS_WR, ptab_pkg::CMD_SPD_WR, ptab_pkg::CMD_ACC_WR,
            ptab_pkg::CMD_DEC_WR, ptab_pkg::CMD_DWL_WR, ptab_pkg::CMD_AUX_WR: begin
               unique case (link.cmd_code)
                  ptab_pkg::CMD_POS_WR: wr_fld = ptab_pkg::FLD_POS;
                  ptab_pkg::CMD_SPD_WR: wr_fld = ptab_pkg::FLD_SPD;
                  ptab_pkg::CMD_ACC_WR: wr_fld = ptab_pkg::FLD_ACC;
                  ptab_pkg::CMD_DEC_WR: wr_fld = ptab_pkg::FLD_DEC;
                  ptab_pkg::CMD_DWL_WR: wr_fld = ptab_pkg::FLD_DWL;
                  default: wr_fld = ptab_pkg::FLD_AUX;
               endcase
               ram_we = (link.cmd_dno != 8'h00);
               nv_we = ram_we && (link.cmd_mode == ptab_pkg::MODE_NV_RAM);
               rsp_valid_d = !link.cmd_to_group;
               rsp_err_d = !ram_we;
            end
            ptab_pkg::CMD_POS_RD, ptab_pkg::CMD_SPD_RD, ptab_pkg::CMD_ACC_RD,
            ptab_pkg::CMD_DEC_RD, ptab_pkg::CMD_DWL_RD, ptab_pkg::CMD_AUX_RD: begin
               unique case (link.cmd_code)
                  ptab_pkg::CMD_POS_RD: wr_fld = ptab_pkg::FLD_POS;
                  ptab_pkg::CMD_SPD_RD: wr_fld = ptab_pkg::FLD_SPD;
                  ptab_pkg::CMD_ACC_RD: wr_fld = ptab_pkg::FLD_ACC;
                  ptab_pkg::CMD_DEC_RD: wr_fld = ptab_pkg::FLD_DEC;
                  ptab_pkg::CMD_DWL_RD: wr_fld = ptab_pkg::FLD_DWL;
                  default: wr_fld = ptab_pkg::FLD_AUX;
               endcase
               rsp_valid_d = rsp_en_q;
               rsp_err_d = (link.cmd_dno == 8'h00);
               rsp_data_d = ram_q[wr_fld][link.cmd_dno];
            end
            ptab_pkg::CMD_GRP_WR: begin
               if (link.cmd_dno == ptab_pkg::DNO_GROUP) begin
                  grp_d = link.cmd_data[7:0];
                  rsp_en_d = link.cmd_data[ptab_pkg::GRP_RSP_EN_BIT];
               end
               rsp_valid_d = !link.cmd_to_group;
               rsp_err_d = (link.cmd_dno != ptab_pkg::DNO_GROUP);
            end
            ptab_pkg::CMD_GRP_RD: begin
               rsp_valid_d = rsp_en_q;
               rsp_err_d = (link.cmd_dno != ptab_pkg::DNO_GROUP);
               rsp_data_d = {23'h0, rsp_en_q, grp_q};
            end
            ptab_pkg::CMD_MON_RD: begin
               rsp_valid_d = rsp_en_q;
               unique case (link.cmd_dno)
                  ptab_pkg::DNO_ABS_PULSE: rsp_data_d = abs_pulse;
                  ptab_pkg::DNO_ABS_CMD: rsp_data_d = cmd_unit_pos;
                  ptab_pkg::DNO_VERSION: rsp_data_d = SW_VERSION;
                  default: rsp_err_d = 1'b1;
               endcase
            end
            default: begin
               rsp_valid_d = !link.cmd_to_group;
               rsp_err_d = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= S_RELOAD;
         idx_q <= ptab_pkg::RELOAD_FIRST;
         grp_q <= ptab_pkg::GRP_RESET;
         rsp_en_q <= ptab_pkg::GRP_RSP_EN_RESET;
         ovf_q <= 1'b0;
         rsp_valid_q <= 1'b0;
         rsp_data_q <= 32'h0;
         rsp_err_q <= 1'b0;
      end else begin
         state_q <= state_d;
         idx_q <= idx_d;
         grp_q <= grp_d;
         rsp_en_q <= rsp_en_d;
         ovf_q <= ovf_d;
         rsp_valid_q <= rsp_valid_d;
         rsp_data_q <= rsp_data_d;
         rsp_err_q <= rsp_err_d;
      end
   end

   // -----------------------------------------------------------------
   // Table memories
   // -----------------------------------------------------------------
   // A RAM-only write is lost at the next reset because the reload
   // sweep overwrites every working entry from the non-volatile copy.
   always_ff @(posedge clk) begin
      if (state_q == S_RELOAD) begin
         for (int f = 0; f < ptab_pkg::FIELDS; f++) begin
            ram_q[f][idx_q] <= nv_q[f][idx_q];
         end
      end else if (ram_we) begin
         ram_q[wr_fld][link.cmd_dno] <= link.cmd_data;
      end
      if (nv_we) begin
         nv_q[wr_fld][link.cmd_dno] <= link.cmd_data;
      end
   end
endmodule
`default_nettype wire

// [ptab_host.sv]
// Master end: issues one command at a time and collects the reply.
`default_nettype none
module ptab_host #(
   parameter longint unsigned NV_GAP_CYCLES = ptab_pkg::NV_GAP_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   ptab_if.host link,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [7:0] req_code,
   input wire logic [7:0] req_dno,
   input wire logic [31:0] req_data,
   input wire logic req_mode,
   input wire logic [7:0] req_dest,
   input wire logic req_to_group,
   output logic done,
   output logic [31:0] done_data,
   output logic done_err,
   output logic done_timeout,
   output logic mode_demoted
);
   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_SEND = 2'b01,
      H_WAIT = 2'b10
   } host_state_t;

   host_state_t state_q, state_d;
   logic [7:0] code_q, code_d, dno_q, dno_d, dest_q, dest_d, tmr_q, tmr_d;
   logic [31:0] data_q, data_d, ddata_q, ddata_d;
   logic mode_q, mode_d, grp_q, grp_d;
   logic done_q, done_d, err_q, err_d, tmo_q, tmo_d, dem_q, dem_d;
   logic [39:0] gap_q, gap_d;
   logic is_wr;

   assign req_ready = (state_q == H_IDLE);
   assign link.cmd_valid = (state_q == H_SEND);
   assign link.cmd_code = code_q;
   assign link.cmd_dno = dno_q;
   assign link.cmd_data = data_q;
   assign link.cmd_mode = mode_q;
   assign link.cmd_dest = dest_q;
   assign link.cmd_to_group = grp_q;
   assign done = done_q;
   assign done_data = ddata_q;
   assign done_err = err_q;
   assign done_timeout = tmo_q;
   assign mode_demoted = dem_q;

   always_comb begin
      is_wr = (req_code == ptab_pkg::CMD_POS_WR) || (req_code == ptab_pkg::CMD_SPD_WR)
         || (req_code == ptab_pkg::CMD_ACC_WR) || (req_code == ptab_pkg::CMD_DEC_WR)
         || (req_code == ptab_pkg::CMD_DWL_WR) || (req_code == ptab_pkg::CMD_AUX_WR);
      state_d = state_q;
      code_d = code_q;
      dno_d = dno_q;
      dest_d = dest_q;
      data_d = data_q;
      mode_d = mode_q;
      grp_d = grp_q;
      tmr_d = tmr_q;
      ddata_d = ddata_q;
      done_d = 1'b0;
      err_d = err_q;
      tmo_d = tmo_q;
      dem_d = dem_q;
      gap_d = (gap_q < 40'(NV_GAP_CYCLES)) ? gap_q + 40'h1 : gap_q;
      unique case (state_q)
         H_IDLE: begin
            if (req_valid) begin
               code_d = req_code;
               dno_d = req_dno;
               data_d = req_data;
               dest_d = req_dest;
               grp_d = req_to_group;
               mode_d = req_mode;
               dem_d = 1'b0;
               state_d = H_SEND;
               // Non-volatile storage wears out, so writes closer together
               // than the gap are sent RAM-only.
               if (is_wr && req_mode == ptab_pkg::MODE_NV_RAM) begin
                  if (gap_q < 40'(NV_GAP_CYCLES)) begin
                     mode_d = ptab_pkg::MODE_RAM;
                     dem_d = 1'b1;
                  end else begin
                     gap_d = 40'h0;
                  end
               end
            end
         end
         H_SEND: begin
            if (link.cmd_ready) begin
               tmr_d = 8'h00;
               state_d = H_WAIT;
            end
         end
         H_WAIT: begin
            tmr_d = tmr_q + 8'h01;
            if (link.rsp_valid) begin
               ddata_d = link.rsp_data;
               err_d = link.rsp_err;
               tmo_d = 1'b0;
               done_d = 1'b1;
               state_d = H_IDLE;
            end else if (tmr_q == ptab_pkg::RSP_TIMEOUT_CYCLES) begin
               // Group writes and disabled read replies end here.
               err_d = 1'b0;
               tmo_d = 1'b1;
               done_d = 1'b1;
               state_d = H_IDLE;
            end
         end
         default: state_d = H_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= H_IDLE;
         code_q <= 8'h00;
         dno_q <= 8'h00;
         dest_q <= 8'h00;
         data_q <= 32'h0;
         mode_q <= 1'b0;
         grp_q <= 1'b0;
         tmr_q <= 8'h00;
         ddata_q <= 32'h0;
         done_q <= 1'b0;
         err_q <= 1'b0;
         tmo_q <= 1'b0;
         dem_q <= 1'b0;
         gap_q <= 40'hff_ffff_ffff;
      end else begin
         state_q <= state_d;
         code_q <= code_d;
         dno_q <= dno_d;
         dest_q <= dest_d;
         data_q <= data_d;
         mode_q <= mode_d;
         grp_q <= grp_d;
         tmr_q <= tmr_d;
         ddata_q <= ddata_d;
         done_q <= done_d;
         err_q <= err_d;
         tmo_q <= tmo_d;
         dem_q <= dem_d;
         gap_q <= gap_d;
      end
   end
endmodule
`default_nettype wire

// [ptab_properties.sv]
// Link checker for the point-table command interface.
`default_nettype none
module ptab_properties #(
   parameter logic [7:0] STATION = 8'h05,
   // Arbitrary neutral version code.
   parameter logic [31:0] SW_VERSION = 32'h30303031
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic [7:0] cmd_code,
   input wire logic [7:0] cmd_dno,
   input wire logic [31:0] cmd_data,
   input wire logic cmd_mode,
   input wire logic [7:0] cmd_dest,
   input wire logic cmd_to_group,
   input wire logic rsp_valid,
   input wire logic [31:0] rsp_data,
   input wire logic rsp_err
);
   logic take, own, wr_tbl, rd_any;
   logic [8:0] cnt_q, cnt_d, grp_q, grp_d;
   assign take = cmd_valid && cmd_ready;
   assign own = take && !cmd_to_group && cmd_dest == STATION;
   assign wr_tbl = cmd_code inside {ptab_pkg::CMD_POS_WR, ptab_pkg::CMD_SPD_WR,
      ptab_pkg::CMD_ACC_WR, ptab_pkg::CMD_DEC_WR, ptab_pkg::CMD_DWL_WR, ptab_pkg::CMD_AUX_WR};
   assign rd_any = cmd_code inside {ptab_pkg::CMD_POS_RD, ptab_pkg::CMD_SPD_RD,
      ptab_pkg::CMD_ACC_RD, ptab_pkg::CMD_DEC_RD, ptab_pkg::CMD_DWL_RD, ptab_pkg::CMD_AUX_RD,
      ptab_pkg::CMD_GRP_RD, ptab_pkg::CMD_MON_RD};
   // ----------------------------------------------------------------
   // Shadow of the group setting and cycles since reset release
   // ----------------------------------------------------------------
   always_comb begin
      cnt_d = (cnt_q == 9'h1ff) ? cnt_q : cnt_q + 9'h001;
      grp_d = grp_q;
      if (own && cmd_code == ptab_pkg::CMD_GRP_WR && cmd_dno == ptab_pkg::DNO_GROUP) begin
         grp_d = cmd_data[8:0];
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 9'h000;
         grp_q <= 9'h100;
      end else begin
         cnt_q <= cnt_d;
         grp_q <= grp_d;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   a_write_ack: assert property (own && wr_tbl && cmd_dno != 8'h00 |=>
      rsp_valid && !rsp_err) else $error("table write not acknowledged");
   a_entry_zero_err: assert property (own && wr_tbl && cmd_dno == 8'h00 |=>
      rsp_valid && rsp_err) else $error("entry zero write not refused");
   a_group_write_silent: assert property (take && cmd_to_group && wr_tbl |=>
      !rsp_valid) else $error("group write answered");
   a_reply_cause: assert property (rsp_valid |-> $past(cmd_valid && cmd_ready))
      else $error("reply without a command");
   a_read_silenced: assert property (own && rd_any && !grp_q[8] |=> !rsp_valid)
      else $error("read answered with responses disabled");
   a_group_readback: assert property (own && cmd_code == ptab_pkg::CMD_GRP_RD && grp_q[8] &&
      cmd_dno == ptab_pkg::DNO_GROUP |=>
      rsp_valid && !rsp_err && rsp_data == {23'h0, $past(grp_q)})
      else $error("group read reply wrong");
   a_version_reply: assert property (own && cmd_code == ptab_pkg::CMD_MON_RD &&
      cmd_dno == ptab_pkg::DNO_VERSION && grp_q[8] |=> rsp_valid && rsp_data == SW_VERSION)
      else $error("version reply wrong");
   a_reload_hold: assert property (cnt_q < 9'h100 |-> !cmd_ready)
      else $error("command taken during reload");
   a_reload_done: assert property (cnt_q >= 9'h100 |-> cmd_ready)
      else $error("reload did not finish");
endmodule
`default_nettype wire

// [point_table_command_handler_tb.sv]
// Self-checking bench: master end and station end joined over one link.
`default_nettype none
module point_table_command_handler_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] STN = 8'h05;
   localparam logic [7:0] GRP = 8'h3c;
   // Arbitrary neutral version code.
   localparam logic [31:0] VER = 32'h31323334;
   logic clk, rst_n, req_valid, req_ready, req_mode, req_to_group, done, done_err;
   logic done_timeout, mode_demoted, pos_overflow, reload_busy, rsp_enable;
   logic [7:0] req_code, req_dno, req_dest, group_id, d;
   logic [31:0] req_data, done_data, cmd_unit_pos;
   logic signed [15:0] motor_rev;
   logic [17:0] motor_pulse;
   logic [31:0] ram [0:5][0:255];
   logic [31:0] nv [0:5][0:255];
   logic [7:0] wr_c [0:5] = '{8'hc0, 8'hc6, 8'hc7, 8'hc8, 8'hca, 8'hcb};
   logic [7:0] rd_c [0:5] = '{8'h40, 8'h50, 8'h54, 8'h58, 8'h60, 8'h64};
   logic signed [15:0] revs [0:3] = '{16'sh1fff, 16'sh2000, -16'sh2000, -16'sh2001};
   logic [3:0] ovf = 4'he;
   int num_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   ptab_if link ();
   ptab_device #(.SW_VERSION(VER)) i_ptab_device (.clk(clk), .rst_n(rst_n), .link(link),
      .station_id(STN), .motor_rev(motor_rev), .motor_pulse(motor_pulse),
      .cmd_unit_pos(cmd_unit_pos), .pos_overflow(pos_overflow), .reload_busy(reload_busy),
      .group_id(group_id), .rsp_enable(rsp_enable));
   // A short gap keeps the wear limiter observable in a short run.
   ptab_host #(.NV_GAP_CYCLES(50)) i_ptab_host (.clk(clk), .rst_n(rst_n), .link(link),
      .req_valid(req_valid), .req_ready(req_ready), .req_code(req_code), .req_dno(req_dno),
      .req_data(req_data), .req_mode(req_mode), .req_dest(req_dest),
      .req_to_group(req_to_group), .done(done), .done_data(done_data), .done_err(done_err),
      .done_timeout(done_timeout), .mode_demoted(mode_demoted));
   ptab_properties #(.STATION(STN), .SW_VERSION(VER)) i_ptab_properties (.clk(clk),
      .rst_n(rst_n), .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready),
      .cmd_code(link.cmd_code), .cmd_dno(link.cmd_dno), .cmd_data(link.cmd_data),
      .cmd_mode(link.cmd_mode), .cmd_dest(link.cmd_dest), .cmd_to_group(link.cmd_to_group),
      .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data), .rsp_err(link.rsp_err));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         conclude();
      end
   end
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic conclude();
      if (num_errors == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Called at a falling edge; returns at the falling edge where done shows.
   task automatic req(input logic [7:0] code, input logic [7:0] dno, input logic [31:0] data,
      input logic mode, input logic grp);
      int n;
      req_code = code;
      req_dno = dno;
      req_data = data;
      req_mode = mode;
      req_to_group = grp;
      req_dest = grp ? GRP : STN;
      req_valid = 1'b1;
      n = 0;
      while (req_ready !== 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      req_valid = 1'b0;
      while (done !== 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      if (n >= 400) begin
         num_errors++;
         conclude();
      end
   endtask
   task automatic wr(input int f, input logic [7:0] e, input logic [31:0] v, input logic m,
      input logic grp);
      req(wr_c[f], e, v, m, grp);
      ram[f][e] = v;
   endtask
   task automatic rd(input int f, input logic [7:0] e);
      req(rd_c[f], e, 32'h0, 1'b0, 1'b0);
      chk("table read", done_data, ram[f][e]);
   endtask
   task automatic do_reset();
      int n;
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      chk("reload busy", {31'h0, reload_busy}, 32'h1);
      n = 0;
      while (reload_busy !== 1'b0 && n < 300) begin
         @(negedge clk);
         n++;
      end
      chk("reload length", {31'h0, n == 255}, 32'h1);
      ram = nv;
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      req_valid = 1'b0;
      req_code = 8'h00;
      req_dno = 8'h00;
      req_data = 32'h0;
      req_mode = 1'b0;
      req_dest = 8'h00;
      req_to_group = 1'b0;
      motor_rev = 16'sh0000;
      motor_pulse = 18'h00000;
      cmd_unit_pos = 32'h0;
      void'($urandom(32'haf88613a));
      do_reset();
      req(ptab_pkg::CMD_GRP_RD, ptab_pkg::DNO_GROUP, 32'h0, 1'b0, 1'b0);
      chk("group reset", done_data, 32'h100);
      for (int f = 0; f < 6; f++) begin
         for (int k = 0; k < 3; k++) begin
            d = (k == 0) ? 8'h01 : (k == 1) ? 8'hff : 8'($urandom_range(2, 254));
            wr(f, d, $urandom(), 1'b1, 1'b0);
            chk("write err", {31'h0, done_err}, 32'h0);
            chk("demoted", {31'h0, mode_demoted}, 32'h0);
            rd(f, d);
         end
         req(wr_c[f], 8'h00, 32'h1, 1'b1, 1'b0);
         chk("entry zero", {31'h0, done_err}, 32'h1);
      end
      req(ptab_pkg::CMD_GRP_WR, ptab_pkg::DNO_GROUP, {23'h0, 1'b1, GRP}, 1'b0, 1'b0);
      chk("group id", {24'h0, group_id}, {24'h0, GRP});
      wr(0, 8'h07, $urandom(), 1'b1, 1'b1);
      chk("group write silent", {31'h0, done_timeout}, 32'h1);
      rd(0, 8'h07);
      req(ptab_pkg::CMD_GRP_WR, ptab_pkg::DNO_GROUP, {23'h0, 1'b0, GRP}, 1'b0, 1'b0);
      chk("rsp enable", {31'h0, rsp_enable}, 32'h0);
      req(ptab_pkg::CMD_GRP_RD, ptab_pkg::DNO_GROUP, 32'h0, 1'b0, 1'b0);
      chk("silenced read", {31'h0, done_timeout}, 32'h1);
      req(ptab_pkg::CMD_GRP_WR, ptab_pkg::DNO_GROUP, {23'h0, 1'b1, GRP}, 1'b0, 1'b0);
      req(ptab_pkg::CMD_GRP_RD, ptab_pkg::DNO_GROUP, 32'h0, 1'b0, 1'b0);
      chk("group read", done_data, {23'h0, 1'b1, GRP});
      motor_pulse = 18'($urandom());
      cmd_unit_pos = $urandom();
      for (int k = 0; k < 4; k++) begin
         motor_rev = revs[k];
         req(ptab_pkg::CMD_MON_RD, ptab_pkg::DNO_ABS_PULSE, 32'h0, 1'b0, 1'b0);
         chk("pulse position", done_data, {motor_rev[13:0], motor_pulse});
         chk("overflow", {31'h0, pos_overflow}, {31'h0, ovf[k]});
      end
      req(ptab_pkg::CMD_MON_RD, ptab_pkg::DNO_ABS_CMD, 32'h0, 1'b0, 1'b0);
      chk("command position", done_data, cmd_unit_pos);
      req(ptab_pkg::CMD_MON_RD, ptab_pkg::DNO_VERSION, 32'h0, 1'b0, 1'b0);
      chk("version", done_data, VER);
      // A second mode-0 write right away must be held back from the non-volatile copy.
      wr(5, 8'h20, 32'h0000a5a5, 1'b0, 1'b0);
      nv[5][8'h20] = 32'h0000a5a5;
      chk("first nv write", {31'h0, mode_demoted}, 32'h0);
      wr(5, 8'h20, 32'h00005a5a, 1'b0, 1'b0);
      chk("second nv write", {31'h0, mode_demoted}, 32'h1);
      rd(5, 8'h20);
      do_reset();
      rd(5, 8'h20);
      conclude();
   end
endmodule
`default_nettype wire
